/* sbcmst_cmd_if.sv */
// Carrier for finished serial frames between receiver and mode logic
`timescale 1ns/1ps
interface sbcmst_cmd_if;
    logic       cs_rise;
    logic       cmd_valid;
    logic [7:0] cmd_data;

    modport rx   (output cs_rise, output cmd_valid, output cmd_data);
    modport core (input cs_rise, input cmd_valid, input cmd_data);
endinterface : sbcmst_cmd_if

/* sbcmst_core.sv */
// Operating-mode sequencer with switch, wake and dominant-timeout logic
//
// Function
// - A stop command finished by select rise puts the device in Stop within 5.0 us.
// - Normal Request without a watchdog trigger times out after 110 to 205 ms.
// - A switch command changes the high-side or low-side output within 10 us.
// - A watchdog trigger in Normal Request reaches Normal within 10 us.
// - A select wake from Stop reaches Normal Request 9.0 to 80 us later.
// - In Sleep and Stop a bus wake counts only after a 42 to 95 us deglitch.
// - In Stop the interrupt goes low 9.0 to 17 us after the bus wake threshold.
// - Transmit held dominant for 0.65 to 1.35 s is a permanent-dominant fault.
// - In Stop a select low-to-high transition is a wake-up.
// - Normal Request is entered as soon as the reset line is released.
// - A frame is exactly 8 bits and is latched on select rise.
`timescale 1ns/1ps
module sbcmst_core
    import sbcmst_pkg::*;
#(
    parameter int NRTOUT_CYC_P = NRTOUT_CYC,
    parameter int TXDDOM_CYC_P = TXDDOM_CYC,
    parameter int PROPWL_CYC_P = PROPWL_CYC,
    parameter int RST_CYC_P    = RST_CYC
) (
    // Clock and reset
    input  wire logic         clock_in,
    input  wire logic         sys_rst_in,
    // Serial pins
    input  wire logic         cs_n_in,
    input  wire logic         sclk_in,
    input  wire logic         mosi_in,
    // Reset line, open drain
    input  wire logic         rst_line_in,
    output logic              rst_line_out,
    output logic              rst_line_oe_n_out,
    // Bus side
    input  wire logic         txd_in,
    input  wire logic         lin_wake_in,
    output logic              lin_tx_out,
    output logic              txd_fault_out,
    // Switches
    input  wire logic         pwm_control_input_in,
    output logic              high_side_switch_out,
    output logic              low_side_switch_out,
    // Status
    output logic              irq_n_out,
    output logic              reg_on_out,
    output sbcmst_mode_e      mode_out
);

    // Outer bounds of the select wake, checked by assertion only
    localparam int WAKE_MIN_CYC = int'(9.0 * CLK_MHZ_R);
    localparam int WAKE_MAX_CYC = int'(80.0 * CLK_MHZ_R);

    if (NRTOUT_CYC_P < 2 || TXDDOM_CYC_P < 2 || PROPWL_CYC_P <= WAKE_CYC || RST_CYC_P < 2)
        $error("sbcmst_core: timing parameters out of range");

    sbcmst_cmd_if cmd ();

    sbcmst_spi_rx u_rx (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .cs_n_in    (cs_n_in),
        .sclk_in    (sclk_in),
        .mosi_in    (mosi_in),
        .cmd        (cmd.rx)
    );

    sbcmst_mode_e mode_reg,  mode_next;
    logic [31:0]  tmr_reg,   tmr_next;
    logic [31:0]  lin_cnt_reg, lin_cnt_next;
    logic [31:0]  txd_cnt_reg, txd_cnt_next;
    logic         oe_n_reg,  oe_n_next;
    logic         irq_n_reg, irq_n_next;
    logic         reg_on_reg, reg_on_next;
    logic         hs_reg,    hs_next;
    logic         ls_reg,    ls_next;
    logic         pwm_reg,   pwm_next;
    logic         fault_reg, fault_next;
    logic         hs_out_reg, hs_out_next;
    logic         ls_out_reg, ls_out_next;
    logic         tx_reg,    tx_next;
    logic         accept;
    logic [1:0]   op;
    logic         lin_ok;
    logic         active_next;

    function automatic logic is_awake(input sbcmst_mode_e m);
        return (m == ST_NREQ) || (m == ST_NORMAL);
    endfunction

    always_comb begin
        mode_next    = mode_reg;
        tmr_next     = tmr_reg;
        lin_cnt_next = 32'h0000_0000;
        txd_cnt_next = 32'h0000_0000;
        oe_n_next    = oe_n_reg;
        irq_n_next   = irq_n_reg;
        hs_next      = hs_reg;
        ls_next      = ls_reg;
        pwm_next     = pwm_reg;
        fault_next   = fault_reg;
        // Commands only taken while awake; during a select wake they are dropped
        accept = cmd.cmd_valid && is_awake(mode_reg);
        op     = cmd.cmd_data[OP_POS +: 2];
        lin_ok = lin_wake_in && (lin_cnt_reg == 32'(PROPWL_CYC_P - 1));

        // Bus wake deglitch, restarted by any gap in the level
        if ((mode_reg == ST_STOP || mode_reg == ST_SLEEP) && lin_wake_in) begin
            lin_cnt_next = lin_cnt_reg + 32'h0000_0001;
        end

        // Any accepted command acknowledges the interrupt; a new event still wins
        if (accept) begin
            irq_n_next = 1'b1;
        end
        if (mode_reg == ST_STOP && lin_wake_in && lin_cnt_reg == 32'(WAKE_CYC - 1)) begin
            irq_n_next = 1'b0;
        end

        if (accept && op == OP_SWITCH) begin
            hs_next  = cmd.cmd_data[SW_HS_POS];
            ls_next  = cmd.cmd_data[SW_LS_POS];
            pwm_next = cmd.cmd_data[SW_PWM_POS];
        end

        case (mode_reg)
            ST_RESET: begin
                if (tmr_reg < 32'(RST_CYC_P - 1)) begin
                    tmr_next = tmr_reg + 32'h0000_0001;
                end else begin
                    oe_n_next = 1'b1;
                    if (oe_n_reg && rst_line_in) begin
                        mode_next = ST_NREQ;
                        tmr_next  = 32'h0000_0000;
                    end
                end
            end
            ST_NREQ, ST_NORMAL: begin
                tmr_next = tmr_reg + 32'h0000_0001;
                if (!rst_line_in) begin
                    // Host pulled reset: hold it through our own pulse
                    mode_next  = ST_RESET;
                    tmr_next   = 32'h0000_0000;
                    oe_n_next  = 1'b0;
                end else if (accept && op == OP_STOP) begin
                    mode_next = ST_STOP;
                end else if (accept && op == OP_SLEEP) begin
                    mode_next = ST_SLEEP;
                end else if (accept && op == OP_WDTRIG && mode_reg == ST_NREQ) begin
                    mode_next = ST_NORMAL;
                end else if (mode_reg == ST_NREQ && tmr_reg == 32'(NRTOUT_CYC_P - 1)) begin
                    mode_next  = ST_RESET;
                    tmr_next   = 32'h0000_0000;
                    oe_n_next  = 1'b0;
                end
            end
            ST_STOP: begin
                tmr_next = 32'h0000_0000;
                if (cmd.cs_rise) begin
                    mode_next = ST_WAKE;
                end else if (lin_ok) begin
                    mode_next = ST_NREQ;
                end
            end
            ST_WAKE: begin
                tmr_next = tmr_reg + 32'h0000_0001;
                if (tmr_reg == 32'(WUCS_CYC - 1)) begin
                    mode_next = ST_NREQ;
                    tmr_next  = 32'h0000_0000;
                end
            end
            ST_SLEEP: begin
                tmr_next = 32'h0000_0000;
                if (lin_ok) begin
                    // Regulator was off, so the host gets a full reset pulse
                    mode_next  = ST_RESET;
                    oe_n_next  = 1'b0;
                end
            end
            default: begin
                mode_next  = ST_RESET;
                tmr_next   = 32'h0000_0000;
                oe_n_next  = 1'b0;
            end
        endcase

        // Permanent-dominant detection on the transmit input
        if (!txd_in) begin
            if (txd_cnt_reg != 32'(TXDDOM_CYC_P - 1)) begin
                txd_cnt_next = txd_cnt_reg + 32'h0000_0001;
            end else begin
                txd_cnt_next = txd_cnt_reg;
                fault_next   = 1'b1;
            end
        end else begin
            fault_next = 1'b0;
        end

        active_next = is_awake(mode_next);
        hs_out_next = active_next && hs_next && (!pwm_next || pwm_control_input_in);
        ls_out_next = active_next && ls_next && (!pwm_next || pwm_control_input_in);
        tx_next     = txd_in || fault_next || !active_next;
        reg_on_next = (mode_next != ST_SLEEP);
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            mode_reg    <= ST_RESET;
            tmr_reg     <= 32'h0000_0000;
            lin_cnt_reg <= 32'h0000_0000;
            txd_cnt_reg <= 32'h0000_0000;
            oe_n_reg    <= 1'b0;
            irq_n_reg   <= 1'b1;
            reg_on_reg  <= 1'b1;
            hs_reg      <= 1'b0;
            ls_reg      <= 1'b0;
            pwm_reg     <= 1'b0;
            fault_reg   <= 1'b0;
            hs_out_reg  <= 1'b0;
            ls_out_reg  <= 1'b0;
            tx_reg      <= 1'b1;
        end else begin
            mode_reg    <= mode_next;
            tmr_reg     <= tmr_next;
            lin_cnt_reg <= lin_cnt_next;
            txd_cnt_reg <= txd_cnt_next;
            oe_n_reg    <= oe_n_next;
            irq_n_reg   <= irq_n_next;
            reg_on_reg  <= reg_on_next;
            hs_reg      <= hs_next;
            ls_reg      <= ls_next;
            pwm_reg     <= pwm_next;
            fault_reg   <= fault_next;
            hs_out_reg  <= hs_out_next;
            ls_out_reg  <= ls_out_next;
            tx_reg      <= tx_next;
        end
    end

    assign mode_out             = mode_reg;
    assign rst_line_out         = oe_n_reg;
    assign rst_line_oe_n_out    = oe_n_reg;
    assign irq_n_out            = irq_n_reg;
    assign reg_on_out           = reg_on_reg;
    assign high_side_switch_out = hs_out_reg;
    assign low_side_switch_out  = ls_out_reg;
    assign lin_tx_out           = tx_reg;
    assign txd_fault_out        = fault_reg;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    a_stop_entry: assert property (
        (accept && op == OP_STOP && rst_line_in) |=> (mode_reg == ST_STOP) [*2])
        else $error("stop command did not reach stop");
    a_nreq_timeout: assert property (
        (mode_reg == ST_NREQ && tmr_reg == 32'(NRTOUT_CYC_P - 1) && rst_line_in && !accept)
        |=> (mode_reg == ST_RESET && !rst_line_oe_n_out))
        else $error("normal request did not time out");
    a_switch_follow: assert property (
        (accept && op == OP_SWITCH && rst_line_in && !cmd.cmd_data[SW_PWM_POS])
        |=> (high_side_switch_out == $past(cmd.cmd_data[SW_HS_POS]))
            && (low_side_switch_out == $past(cmd.cmd_data[SW_LS_POS])))
        else $error("switch output did not follow command");
    a_wd_normal: assert property (
        (mode_reg == ST_NREQ && accept && op == OP_WDTRIG && rst_line_in)
        |=> mode_reg == ST_NORMAL)
        else $error("watchdog trigger did not reach normal");
    a_cs_wake_time: assert property (
        (mode_reg == ST_WAKE) |=> (mode_reg == ST_WAKE && tmr_reg < 32'(WAKE_MAX_CYC))
            || (mode_reg == ST_NREQ && reg_on_out && rst_line_oe_n_out
                && $past(tmr_reg) >= 32'(WAKE_MIN_CYC - 2)))
        else $error("select wake timing wrong");
    a_cs_wake_entry: assert property (
        (mode_reg == ST_STOP && cmd.cs_rise) |=> mode_reg == ST_WAKE)
        else $error("select rise in stop did not wake");
    a_lin_deglitch: assert property (
        (mode_reg == ST_STOP && !cmd.cs_rise && !lin_ok) |=> mode_reg == ST_STOP)
        else $error("stop left without a filtered wake");
    a_irq_stop: assert property (
        (mode_reg == ST_STOP && lin_wake_in && lin_cnt_reg == 32'(WAKE_CYC - 1))
        |=> !irq_n_out)
        else $error("interrupt not raised on bus wake");
    a_txd_fault: assert property (
        (!txd_in && txd_cnt_reg == 32'(TXDDOM_CYC_P - 1)) |=> (txd_fault_out && lin_tx_out))
        else $error("dominant timeout not flagged");
    a_reset_release: assert property (
        (mode_reg == ST_RESET && rst_line_oe_n_out && rst_line_in) |=> mode_reg == ST_NREQ)
        else $error("reset release did not enter normal request");

endmodule // sbcmst_core

/* sbcmst_host_model.sv */
// Host controller model driving the serial pins and the reset pull
`timescale 1ns/1ps
module sbcmst_host_model (
    // Clock
    input  wire logic clock_in,
    // Host-driven pins
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      mosi_out,
    output logic      rst_pull_out
);
    int cs_high_cnt = 1000;

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
        rst_pull_out = 1'b0;
    end

    always @(posedge clock_in) begin
        cs_high_cnt <= cs_n_out ? cs_high_cnt + 1 : 0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    // Host side of the open-drain reset wire, held low for n cycles
    task automatic pull_reset(input int n);
        rst_pull_out = 1'b1;
        tick(n);
        rst_pull_out = 1'b0;
    endtask

    // Fewer than 8 bits gives a refused frame; 0 bits is a bare select pulse
    task automatic send(input logic [7:0] d, input int nbits);
        while (cs_high_cnt < 500) tick(1);
        cs_n_out = 1'b0;
        for (int i = 7; i > 7 - nbits; i--) begin
            tick(2);
            mosi_out = d[i];
            sclk_out = 1'b0;
            tick(2);
            sclk_out = 1'b1;
        end
        tick(2);
        sclk_out = 1'b0;
        // Unselected data line must not keep a stale value
        mosi_out = ~mosi_out;
        tick(2);
        cs_n_out = 1'b1;
    endtask
endmodule // sbcmst_host_model

/* sbcmst_pkg.sv */
// Constants shared by the mode/timing block and its serial receiver
package sbcmst_pkg;

    // Clock
    localparam int  CLK_HZ      = 125_000_000;
    localparam real CLK_MHZ_R   = 125.0;

    // Times, each in its own unit, typical figures
    localparam real T_NRTOUT_MS = 150.0;
    localparam real T_WUCS_US   = 15.0;
    localparam real T_PROPWL_US = 70.0;
    localparam real T_WAKE_US   = 13.0;
    localparam real T_TXDDOM_S  = 1.0;
    localparam real T_RST_MS    = 1.0;

    // Cycle counts derived from the times and the clock rate
    localparam int NRTOUT_CYC  = int'(T_NRTOUT_MS * 1000.0 * CLK_MHZ_R);
    localparam int WUCS_CYC    = int'(T_WUCS_US * CLK_MHZ_R);
    localparam int PROPWL_CYC  = int'(T_PROPWL_US * CLK_MHZ_R);
    localparam int WAKE_CYC    = int'(T_WAKE_US * CLK_MHZ_R);
    localparam int TXDDOM_CYC  = int'(T_TXDDOM_S * 1000000.0 * CLK_MHZ_R);
    localparam int RST_CYC     = int'(T_RST_MS * 1000.0 * CLK_MHZ_R);

    // Serial frame layout
    localparam int        FRAME_BITS  = 8;
    localparam int        OP_POS      = 6;
    localparam logic [1:0] OP_WDTRIG  = 2'h0;
    localparam logic [1:0] OP_STOP    = 2'h1;
    localparam logic [1:0] OP_SLEEP   = 2'h2;
    localparam logic [1:0] OP_SWITCH  = 2'h3;
    localparam int        SW_HS_POS   = 0;
    localparam int        SW_LS_POS   = 1;
    localparam int        SW_PWM_POS  = 2;

    // Operating modes
    typedef enum logic [5:0] {
        ST_RESET  = 6'h01,
        ST_NREQ   = 6'h02,
        ST_NORMAL = 6'h04,
        ST_STOP   = 6'h08,
        ST_WAKE   = 6'h10,
        ST_SLEEP  = 6'h20
    } sbcmst_mode_e;

endpackage : sbcmst_pkg

/* sbcmst_spi_rx.sv */
// Serial command receiver: shifts on clock rise, frames on select rise
`timescale 1ns/1ps
module sbcmst_spi_rx
    import sbcmst_pkg::*;
(
    // Clock and reset
    input  wire logic    clock_in,
    input  wire logic    sys_rst_in,
    // Serial pins
    input  wire logic    cs_n_in,
    input  wire logic    sclk_in,
    input  wire logic    mosi_in,
    // Frames out
    sbcmst_cmd_if.rx     cmd
);

    logic       cs_prev_reg,  cs_prev_next;
    logic       sclk_prev_reg, sclk_prev_next;
    logic [7:0] shift_reg,    shift_next;
    logic [3:0] count_reg,    count_next;
    logic       rise_reg,     rise_next;
    logic       valid_reg,    valid_next;
    logic [7:0] data_reg,     data_next;

    always_comb begin
        cs_prev_next   = cs_n_in;
        sclk_prev_next = sclk_in;
        shift_next     = shift_reg;
        count_next     = count_reg;
        rise_next      = 1'b0;
        valid_next     = 1'b0;
        data_next      = data_reg;
        if (!cs_n_in && sclk_in && !sclk_prev_reg) begin
            shift_next = {shift_reg[6:0], mosi_in};
            // Saturate so a long frame never wraps back to a legal length
            if (count_reg != 4'hF) begin
                count_next = count_reg + 4'h1;
            end
        end
        if (cs_n_in && !cs_prev_reg) begin
            rise_next  = 1'b1;
            count_next = 4'h0;
            if (count_reg == 4'(FRAME_BITS)) begin
                valid_next = 1'b1;
                data_next  = shift_reg;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cs_prev_reg   <= 1'b1;
            sclk_prev_reg <= 1'b0;
            shift_reg     <= 8'h00;
            count_reg     <= 4'h0;
            rise_reg      <= 1'b0;
            valid_reg     <= 1'b0;
            data_reg      <= 8'h00;
        end else begin
            cs_prev_reg   <= cs_prev_next;
            sclk_prev_reg <= sclk_prev_next;
            shift_reg     <= shift_next;
            count_reg     <= count_next;
            rise_reg      <= rise_next;
            valid_reg     <= valid_next;
            data_reg      <= data_next;
        end
    end

    assign cmd.cs_rise   = rise_reg;
    assign cmd.cmd_valid = valid_reg;
    assign cmd.cmd_data  = data_reg;

    a_frame_length: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (cs_n_in && !cs_prev_reg && count_reg != 4'(FRAME_BITS)) |=> !valid_reg)
        else $error("frame of wrong length accepted");

endmodule // sbcmst_spi_rx

/* tb_sbc_mode_state_timing.sv */
// Self-checking testbench for the mode and timing sequencer
`timescale 1ns/1ps
module tb_sbc_mode_state_timing;
    import sbcmst_pkg::*;
    localparam int NRT  = 15000;
    localparam int TXD  = 300;
    localparam int PWL  = 1700;
    localparam int RSTC = 50;

    logic         clock_in;
    logic         sys_rst_in;
    logic         txd_in;
    logic         lin_wake_in;
    logic         pwm_in;
    wire logic    cs_n;
    wire logic    sclk;
    wire logic    mosi;
    wire logic    rst_pull;
    wire logic    rst_wire;
    logic         oe_n;
    logic         rst_out;
    logic         lin_tx;
    logic         fault;
    logic         hs;
    logic         ls;
    logic         irq_n;
    logic         reg_on;
    sbcmst_mode_e mode;
    int           error_cnt = 0;
    int           cmp_count = 0;

    // Open drain wire with pull-up
    assign rst_wire = oe_n & ~rst_pull;

    sbcmst_host_model host (
        .clock_in     (clock_in),
        .cs_n_out     (cs_n),
        .sclk_out     (sclk),
        .mosi_out     (mosi),
        .rst_pull_out (rst_pull)
    );

    sbcmst_core #(
        .NRTOUT_CYC_P (NRT),
        .TXDDOM_CYC_P (TXD),
        .PROPWL_CYC_P (PWL),
        .RST_CYC_P    (RSTC)
    ) dut (
        .clock_in             (clock_in),
        .sys_rst_in           (sys_rst_in),
        .cs_n_in              (cs_n),
        .sclk_in              (sclk),
        .mosi_in              (mosi),
        .rst_line_in          (rst_wire),
        .rst_line_out         (rst_out),
        .rst_line_oe_n_out    (oe_n),
        .txd_in               (txd_in),
        .lin_wake_in          (lin_wake_in),
        .lin_tx_out           (lin_tx),
        .txd_fault_out        (fault),
        .pwm_control_input_in (pwm_in),
        .high_side_switch_out (hs),
        .low_side_switch_out  (ls),
        .irq_n_out            (irq_n),
        .reg_on_out           (reg_on),
        .mode_out             (mode)
    );

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic chk_mode(input sbcmst_mode_e m);
        chk({2'h0, mode}, {2'h0, m});
    endtask

    task automatic wait_mode(input sbcmst_mode_e m, input int lim, output int n);
        for (n = 0; n < lim && mode !== m; n++) tick(1);
    endtask

    task automatic send_chk(input logic [7:0] d, input sbcmst_mode_e m);
        host.send(d, 8);
        tick(3);
        chk_mode(m);
    endtask

    task automatic t_reset();
        int n;
        tick(20);
        chk_mode(ST_RESET);
        chk({4'h0, oe_n, irq_n, hs, ls}, 8'h04);
        chk({6'h0, lin_tx, reg_on}, 8'h03);
        sys_rst_in = 1'b0;
        wait_mode(ST_NREQ, RSTC + 20, n);
        chk_mode(ST_NREQ);
        chk({7'h0, oe_n}, 8'h01);
        $display("test reset done");
    endtask

    task automatic t_timeout();
        int n;
        tick(NRT - 20);
        chk_mode(ST_NREQ);
        wait_mode(ST_RESET, 40, n);
        chk_mode(ST_RESET);
        wait_mode(ST_NREQ, RSTC + 20, n);
        chk_mode(ST_NREQ);
        send_chk(8'h00, ST_NORMAL);
        $display("test timeout done");
    endtask

    task automatic t_switch();
        host.send(8'hC3, 8);
        tick(3);
        chk({6'h0, hs, ls}, 8'h03);
        host.send(8'hC1, 7);
        tick(3);
        chk({6'h0, hs, ls}, 8'h03);
        host.send(8'hC1, 8);
        tick(3);
        chk({6'h0, hs, ls}, 8'h02);
        host.send(8'hC7, 8);
        tick(3);
        chk({6'h0, hs, ls}, 8'h00);
        // One gate period at the highest allowed rate
        pwm_in = 1'b1;
        tick(6250);
        chk({6'h0, hs, ls}, 8'h03);
        pwm_in = 1'b0;
        tick(6250);
        chk({6'h0, hs, ls}, 8'h00);
        pwm_in = 1'b1;
        host.send(8'hC0, 8);
        tick(3);
        chk({6'h0, hs, ls}, 8'h00);
        $display("test switch done");
    endtask

    task automatic t_txd();
        int n;
        txd_in = 1'b0;
        tick(TXD - 10);
        chk({6'h0, fault, lin_tx}, 8'h00);
        for (n = 0; n < 20 && fault !== 1'b1; n++) tick(1);
        chk({6'h0, fault, lin_tx}, 8'h03);
        txd_in = 1'b1;
        tick(2);
        chk({6'h0, fault, lin_tx}, 8'h01);
        $display("test txd done");
    endtask

    task automatic t_cs_wake();
        int n;
        send_chk(8'h40, ST_STOP);
        host.send(8'h00, 0);
        wait_mode(ST_NREQ, 10000, n);
        chk({7'h0, n >= 1125 && n <= 10000}, 8'h01);
        chk({5'h0, mode == ST_NREQ, reg_on, oe_n}, 8'h07);
        tick(11250 - n);
        send_chk(8'h00, ST_NORMAL);
        $display("test select wake done");
    endtask

    task automatic t_bus_wake();
        int n;
        send_chk(8'h40, ST_STOP);
        lin_wake_in = 1'b1;
        tick(1000);
        lin_wake_in = 1'b0;
        tick(PWL);
        chk({2'h0, mode} | {7'h0, irq_n}, {2'h0, ST_STOP} | 8'h01);
        lin_wake_in = 1'b1;
        for (n = 0; n < 2200 && irq_n !== 1'b0; n++) tick(1);
        chk({7'h0, n >= 1125 && n <= 2125}, 8'h01);
        chk_mode(ST_STOP);
        wait_mode(ST_NREQ, 200, n);
        chk({6'h0, mode == ST_NREQ, irq_n}, 8'h02);
        lin_wake_in = 1'b0;
        send_chk(8'h00, ST_NORMAL);
        chk({7'h0, irq_n}, 8'h01);
        $display("test bus wake done");
    endtask

    task automatic t_sleep_rst();
        int n;
        send_chk(8'h80, ST_SLEEP);
        chk({6'h0, reg_on, lin_tx}, 8'h01);
        lin_wake_in = 1'b1;
        tick(1000);
        lin_wake_in = 1'b0;
        tick(2);
        chk_mode(ST_SLEEP);
        lin_wake_in = 1'b1;
        wait_mode(ST_RESET, PWL + 20, n);
        chk({7'h0, n == PWL}, 8'h01);
        chk({5'h0, mode == ST_RESET, oe_n, rst_out}, 8'h04);
        lin_wake_in = 1'b0;
        wait_mode(ST_NREQ, RSTC + 20, n);
        chk({6'h0, mode == ST_NREQ, rst_out}, 8'h03);
        host.pull_reset(3);
        chk({5'h0, mode == ST_RESET, oe_n, rst_out}, 8'h04);
        wait_mode(ST_NREQ, RSTC + 20, n);
        chk({6'h0, mode == ST_NREQ, oe_n}, 8'h03);
        $display("test sleep and host reset done");
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Tests need about 50000 cycles
    initial begin
        repeat (90000) @(posedge clock_in);
        error_cnt++;
        final_report();
    end

    initial begin
        sys_rst_in = 1'b1;
        txd_in = 1'b1;
        lin_wake_in = 1'b0;
        pwm_in = 1'b0;
        t_reset();
        t_timeout();
        t_switch();
        t_txd();
        t_cs_wake();
        t_bus_wake();
        t_sleep_rst();
        final_report();
    end
endmodule // tb_sbc_mode_state_timing
